// [hw/mac_cfg_pkg.sv]
// Package with register map, field positions and shared types of the MAC control front end
package mac_cfg_pkg;
    localparam logic [7:0] ID_OFFSET = 8'h00;
    localparam logic [7:0] CTRL_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;
    localparam int CMF_BIT = 24;
    localparam int CSF_BIT = 23;
    localparam int CEF_BIT = 22;
    localparam int PIN_SEL_BIT = 18;
    localparam int FORCE_1000_BIT = 17;
    localparam int IFACE_B_BIT = 16;
    localparam int IFACE_A_BIT = 15;
    localparam int IDLE_CMD_BIT = 11;
    localparam int SHORT_GAP_BIT = 10;
    localparam int SPEED_BIT = 7;
    localparam int TX_PACE_BIT = 6;
    localparam int GMII_EN_BIT = 5;
    localparam int TX_FLOW_BIT = 4;
    localparam int RX_FLOW_BIT = 3;
    localparam int MTEST_BIT = 2;
    localparam int LOOPBACK_BIT = 1;
    localparam int FULL_DUPLEX_BIT = 0;
    localparam logic [31:0] CTRL_WRITE_MASK = 32'h01c78cff;
    localparam logic [31:0] CTRL_RESET = 32'h00000000;
    localparam int STAT_IDLE_BIT = 31;
    localparam int STAT_EXT_1000_BIT = 4;
    localparam int STAT_EXT_DUPLEX_BIT = 3;
    localparam int MIN_FRAME_BYTES = 64;
    localparam int IDLE_DRAIN_CYCLES = 4;
    localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

    typedef struct packed {
        logic done;
        logic [15:0] length;
        logic crc_err;
        logic align_err;
        logic code_err;
        logic is_control;
        logic is_pause;
    } rx_frame_t;

    typedef struct packed {
        logic valid;
        logic keep;
        logic control;
        logic fragment;
        logic undersized;
        logic crc_err;
        logic align_err;
        logic code_err;
        logic act_pause;
        logic act_control;
    } rx_verdict_t;
endpackage

// [hw/rx_frame_filter.sv]
// Receive frame filter: decides delivery and end-of-packet flags for each finished frame
`timescale 1ns/1ps
module rx_frame_filter
(
    input wire logic clk_in, // Clock
    input wire logic rst_b_in, // Synchronised reset, active low
    input wire logic copy_control_frames_en_in, // Deliver control frames
    input wire logic copy_short_frames_en_in, // Deliver short frames
    input wire logic copy_error_frames_en_in, // Deliver error frames
    input wire logic pause_en_in, // Pause handling enabled
    input wire logic control_act_en_in, // Control frame handling enabled
    input wire mac_cfg_pkg::rx_frame_t frame_in, // Finished frame summary
    output mac_cfg_pkg::rx_verdict_t verdict_out // Registered verdict
);
    mac_cfg_pkg::rx_verdict_t verdict;
    mac_cfg_pkg::rx_verdict_t next_verdict;
    logic short_frame;
    logic any_err;

    always_comb
    begin
        short_frame = frame_in.length < 16'(mac_cfg_pkg::MIN_FRAME_BYTES);
        any_err = frame_in.crc_err | frame_in.align_err | frame_in.code_err;
        next_verdict = '0;
        next_verdict.valid = frame_in.done;
        if (frame_in.done)
        begin
            // Short filter applies first, then error (long frames only), then control
            next_verdict.keep = 1'b1;
            if (short_frame && !copy_short_frames_en_in)
                next_verdict.keep = 1'b0;
            if (any_err && !short_frame && !copy_error_frames_en_in)
                next_verdict.keep = 1'b0;
            if (frame_in.is_control && !copy_control_frames_en_in)
                next_verdict.keep = 1'b0;
            next_verdict.control = frame_in.is_control && copy_control_frames_en_in;
            next_verdict.fragment = short_frame && any_err;
            next_verdict.undersized = short_frame && !any_err;
            next_verdict.crc_err = frame_in.crc_err;
            next_verdict.align_err = frame_in.align_err;
            next_verdict.code_err = frame_in.code_err;
            // Acting on pause is independent of copying
            next_verdict.act_pause = frame_in.is_pause && pause_en_in;
            next_verdict.act_control = frame_in.is_control && !frame_in.is_pause && control_act_en_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            verdict <= '0;
        else
            verdict <= next_verdict;
    end

    assign verdict_out = verdict;

    a_pause_acted: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (frame_in.done && frame_in.is_pause && pause_en_in) |=> verdict.act_pause)
        else $error("pause frame not acted upon");
    a_control_drop: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (frame_in.done && frame_in.is_control && !copy_control_frames_en_in) |=> !verdict.keep)
        else $error("control frame delivered while copy disabled");
    a_short_flag: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (frame_in.done && frame_in.length < 16'(mac_cfg_pkg::MIN_FRAME_BYTES)) |=> (verdict.fragment ^ verdict.undersized))
        else $error("short frame lacks exactly one flag");
endmodule // rx_frame_filter

// [hw/mac_control_config.sv]
// Top of the MAC configuration front end: register slave, mode selection, idle and filtering
// Summary of operation
// - Control frames reach memory only with copy enabled; otherwise dropped yet acted upon.
// - Pause frames are acted upon whenever pause handling is on and full duplex is in effect.
// - Control frames delivered by copy carry the control flag.
// - Frames under 64 bytes reach memory only with short copy enabled.
// - Short delivered frames flagged fragment if errored, else undersized.
// - Errored frames reach memory with error flags only when error copy enabled; short errored frames follow short copy instead.
// - Pin mode select takes duplex and speed from input pins.
// - Duplex output always shows the full duplex mode in effect.
// - Force gigabit bit puts the MAC into gigabit operation.
// - Two interface control bits drive general purpose outputs directly.
// - Idle request bit commands idle; reaching idle shows in status idle flag.
// - Short gap used only when enabled and short gap input asserted.
// - Speed bit selects 10/100 or gigabit; gigabit is full duplex only.
// - Identification register returns ident, Z, X and Y fields.
// - Duplex bit selects half or full; gigabit forces full duplex.
// - Status idle flag reads one once idle is reached after a command.
// - GMII paths held in reset while GMII enable is zero.
//
// Decided for this implementation: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
module mac_control_config
#(
    parameter logic [15:0] IDENT = 16'h00a5, // Arbitrary identifier value
    parameter logic [4:0] VER_Z = 5'h01, // Arbitrary
    parameter logic [2:0] VER_X = 3'h1, // Arbitrary
    parameter logic [7:0] VER_Y = 8'h00, // Arbitrary
    parameter int IDLE_DRAIN = mac_cfg_pkg::IDLE_DRAIN_CYCLES // Quiet cycles before idle is reported
)
(
    input wire logic ref_clk_in, // 20 MHz clock
    input wire logic rst_b_in, // Asynchronous reset, active low
    input wire logic [7:0] avs_address_in, // Byte address
    input wire logic avs_read_in, // Read request
    input wire logic avs_write_in, // Write request
    input wire logic [31:0] avs_writedata_in, // Write data
    input wire logic [3:0] avs_byteenable_in, // Byte enables
    output logic [31:0] avs_readdata_out, // Read data
    output logic avs_waitrequest_out, // Stall
    input wire logic duplex_pin_in, // External full duplex
    input wire logic speed_pin_in, // External gigabit
    input wire logic short_gap_req_in, // Short gap request
    input wire logic tx_busy_in, // Transmit or receive activity
    input wire mac_cfg_pkg::rx_frame_t rx_frame_in, // Finished receive frame
    output mac_cfg_pkg::rx_verdict_t rx_verdict_out, // Delivery verdict
    output logic full_duplex_out, // Duplex mode in effect
    output logic gigabit_out, // Gigabit mode in effect
    output logic short_gap_out, // Use short gap
    output logic iface_output_a_out, // General purpose output A
    output logic iface_output_b_out, // General purpose output B
    output logic gmii_rst_b_out, // GMII paths reset, active low
    output logic idle_out, // MAC idle reached
    output logic loopback_out, // Loopback mode
    output logic tx_pace_out, // Transmit pacing
    output logic tx_flow_en_out, // Act on pause frames
    output logic rx_flow_en_out // Receive flow control
);
    typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_ACK = 2'b00} bus_state_t;
    typedef enum logic [1:0] {RUN = 2'b00, DRAIN = 2'b01, HALTED = 2'b11} idle_state_t;

    logic rst_meta;
    logic rst_sync;
    bus_state_t bus_state;
    bus_state_t next_bus_state;
    logic [31:0] mac_control;
    logic [31:0] next_mac_control;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic [31:0] mac_state_reg;
    logic [31:0] wmask;
    idle_state_t idle_state;
    idle_state_t next_idle_state;
    logic [7:0] drain_cnt;
    logic [7:0] next_drain_cnt;
    logic eff_1000;
    logic eff_duplex;
    logic next_duplex;
    logic next_gig;
    logic next_short_gap;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // Each access is answered one cycle after it is seen, then waitrequest drops for one edge
    always_comb
    begin
        wmask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                 {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
        next_bus_state = bus_state;
        next_mac_control = mac_control;
        next_rdata = rdata;
        case (bus_state)
            ST_IDLE:
            begin
                if (avs_read_in || avs_write_in)
                begin
                    next_bus_state = ST_ACK;
                    case (avs_address_in)
                        mac_cfg_pkg::ID_OFFSET: next_rdata = {IDENT, VER_Z, VER_X, VER_Y};
                        mac_cfg_pkg::CTRL_OFFSET: next_rdata = mac_control;
                        mac_cfg_pkg::STATUS_OFFSET: next_rdata = mac_state_reg;
                        default: next_rdata = mac_cfg_pkg::UNMAPPED_READ;
                    endcase
                end
            end
            ST_ACK:
            begin
                next_bus_state = ST_IDLE;
                // Write lands at the edge that sees waitrequest low, where the master completes it
                if (avs_write_in && avs_address_in == mac_cfg_pkg::CTRL_OFFSET)
                begin
                    next_mac_control = (mac_control & ~(wmask & mac_cfg_pkg::CTRL_WRITE_MASK))
                        | (avs_writedata_in & wmask & mac_cfg_pkg::CTRL_WRITE_MASK);
                end
            end
            default: next_bus_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            bus_state <= ST_IDLE;
            mac_control <= mac_cfg_pkg::CTRL_RESET;
            rdata <= '0;
        end
        else
        begin
            bus_state <= next_bus_state;
            mac_control <= next_mac_control;
            rdata <= next_rdata;
        end
    end

    // Pin select takes speed and duplex from pins; forced or selected gigabit implies full duplex
    always_comb
    begin
        eff_1000 = mac_control[mac_cfg_pkg::FORCE_1000_BIT]
            | (mac_control[mac_cfg_pkg::PIN_SEL_BIT] ? speed_pin_in
                                                     : mac_control[mac_cfg_pkg::SPEED_BIT]);
        eff_duplex = eff_1000 | mac_control[mac_cfg_pkg::LOOPBACK_BIT]
            | (mac_control[mac_cfg_pkg::PIN_SEL_BIT] ? duplex_pin_in
                                                     : mac_control[mac_cfg_pkg::FULL_DUPLEX_BIT]);
        next_duplex = eff_duplex;
        next_gig = eff_1000;
        next_short_gap = mac_control[mac_cfg_pkg::SHORT_GAP_BIT] & short_gap_req_in;
        mac_state_reg = '0;
        mac_state_reg[mac_cfg_pkg::STAT_IDLE_BIT] = (idle_state == HALTED);
        mac_state_reg[mac_cfg_pkg::STAT_EXT_1000_BIT] = speed_pin_in;
        mac_state_reg[mac_cfg_pkg::STAT_EXT_DUPLEX_BIT] = duplex_pin_in;
    end

    // Idle: wait for activity to stay quiet for IDLE_DRAIN cycles; clearing the command resumes
    always_comb
    begin
        next_idle_state = idle_state;
        next_drain_cnt = drain_cnt;
        case (idle_state)
            RUN:
            begin
                next_drain_cnt = '0;
                if (mac_control[mac_cfg_pkg::IDLE_CMD_BIT])
                    next_idle_state = DRAIN;
            end
            DRAIN:
            begin
                if (!mac_control[mac_cfg_pkg::IDLE_CMD_BIT])
                    next_idle_state = RUN;
                else if (tx_busy_in)
                    next_drain_cnt = '0;
                else if (drain_cnt >= 8'(IDLE_DRAIN - 1))
                    next_idle_state = HALTED;
                else
                    next_drain_cnt = drain_cnt + 8'h01;
            end
            HALTED:
            begin
                if (!mac_control[mac_cfg_pkg::IDLE_CMD_BIT])
                    next_idle_state = RUN;
            end
            default: next_idle_state = RUN;
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            idle_state <= RUN;
            drain_cnt <= '0;
            full_duplex_out <= 1'b0;
            gigabit_out <= 1'b0;
            short_gap_out <= 1'b0;
            iface_output_a_out <= 1'b0;
            iface_output_b_out <= 1'b0;
            gmii_rst_b_out <= 1'b0;
            idle_out <= 1'b0;
            loopback_out <= 1'b0;
            tx_pace_out <= 1'b0;
            tx_flow_en_out <= 1'b0;
            rx_flow_en_out <= 1'b0;
        end
        else
        begin
            idle_state <= next_idle_state;
            drain_cnt <= next_drain_cnt;
            full_duplex_out <= next_duplex;
            gigabit_out <= next_gig;
            short_gap_out <= next_short_gap;
            iface_output_a_out <= mac_control[mac_cfg_pkg::IFACE_A_BIT];
            iface_output_b_out <= mac_control[mac_cfg_pkg::IFACE_B_BIT];
            gmii_rst_b_out <= mac_control[mac_cfg_pkg::GMII_EN_BIT];
            idle_out <= (next_idle_state == HALTED);
            loopback_out <= mac_control[mac_cfg_pkg::LOOPBACK_BIT];
            tx_pace_out <= mac_control[mac_cfg_pkg::TX_PACE_BIT];
            // Pause frames are only honoured in full duplex
            tx_flow_en_out <= mac_control[mac_cfg_pkg::TX_FLOW_BIT] & eff_duplex;
            rx_flow_en_out <= mac_control[mac_cfg_pkg::RX_FLOW_BIT];
        end
    end

    // Stall is bit 0 of the state flop itself
    assign avs_waitrequest_out = bus_state[0];
    assign avs_readdata_out = rdata;

    rx_frame_filter u_filter
    (
        .clk_in(ref_clk_in),
        .rst_b_in(rst_sync),
        .copy_control_frames_en_in(mac_control[mac_cfg_pkg::CMF_BIT]),
        .copy_short_frames_en_in(mac_control[mac_cfg_pkg::CSF_BIT]),
        .copy_error_frames_en_in(mac_control[mac_cfg_pkg::CEF_BIT]),
        .pause_en_in(mac_control[mac_cfg_pkg::TX_FLOW_BIT] & eff_duplex),
        .control_act_en_in(mac_control[mac_cfg_pkg::TX_FLOW_BIT]),
        .frame_in(rx_frame_in),
        .verdict_out(rx_verdict_out)
    );

    sequence s_idle_cmd;
        mac_control[mac_cfg_pkg::IDLE_CMD_BIT] && !tx_busy_in;
    endsequence

    a_idle_reached: assert property (@(posedge ref_clk_in) disable iff (!rst_sync)
        (s_idle_cmd [*6]) |-> idle_out)
        else $error("idle not reached after quiet period");
    a_idle_needs_cmd: assert property (@(posedge ref_clk_in) disable iff (!rst_sync)
        idle_out |-> $past(mac_control[mac_cfg_pkg::IDLE_CMD_BIT]))
        else $error("idle reported without command");
    a_gig_full: assert property (@(posedge ref_clk_in) disable iff (!rst_sync)
        gigabit_out |-> full_duplex_out)
        else $error("gigabit without full duplex");
    a_pin_speed: assert property (@(posedge ref_clk_in) disable iff (!rst_sync)
        mac_control[mac_cfg_pkg::PIN_SEL_BIT] && !mac_control[mac_cfg_pkg::FORCE_1000_BIT]
        |=> gigabit_out == $past(speed_pin_in))
        else $error("speed not taken from pin");
    a_force_gig: assert property (@(posedge ref_clk_in) disable iff (!rst_sync)
        mac_control[mac_cfg_pkg::FORCE_1000_BIT] |=> gigabit_out)
        else $error("force gigabit ignored");
    a_short_gap: assert property (@(posedge ref_clk_in) disable iff (!rst_sync)
        short_gap_out |-> $past(short_gap_req_in && mac_control[mac_cfg_pkg::SHORT_GAP_BIT]))
        else $error("short gap without enable and request");
    a_gmii_reset: assert property (@(posedge ref_clk_in) disable iff (!rst_sync)
        !mac_control[mac_cfg_pkg::GMII_EN_BIT] |=> !gmii_rst_b_out)
        else $error("GMII released while disabled");
    a_iface_a: assert property (@(posedge ref_clk_in) disable iff (!rst_sync)
        iface_output_a_out == $past(mac_control[mac_cfg_pkg::IFACE_A_BIT]))
        else $error("interface output A mismatch");
    a_reserved_zero: assert property (@(posedge ref_clk_in) disable iff (!rst_sync)
        (mac_control & ~mac_cfg_pkg::CTRL_WRITE_MASK) == 32'h00000000)
        else $error("reserved control bit set");
endmodule // mac_control_config

// [sim/phy_frame_model.sv]
// Far-side model: hands finished receive frames to the MAC and shows line activity after each one
`timescale 1ns/1ps
module phy_frame_model
(
    input wire logic clk_in, // Clock
    input wire logic rst_b_in, // Reset, active low
    input wire logic send_in, // Hand over one finished frame
    input wire mac_cfg_pkg::rx_frame_t frame_in, // Frame summary to hand over
    input wire logic [3:0] busy_len_in, // Activity cycles after the frame
    output mac_cfg_pkg::rx_frame_t frame_out, // Summary seen by the MAC
    output logic busy_out // Line activity
);
    logic [3:0] busy_cnt;

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            frame_out <= '0;
            busy_cnt <= 4'h0;
        end
        else if (send_in)
        begin
            frame_out <= frame_in;
            frame_out.done <= 1'b1;
            busy_cnt <= busy_len_in;
        end
        else
        begin
            // Fields flip every cycle while done is low, so stale values never pass for a fresh frame
            frame_out <= ~frame_out;
            frame_out.done <= 1'b0;
            busy_cnt <= (busy_cnt != 4'h0) ? busy_cnt - 4'h1 : 4'h0;
        end
    end

    assign busy_out = (busy_cnt != 4'h0);
endmodule // phy_frame_model

// [sim/gmac_control_config_bench.sv]
// Self-checking testbench of the MAC configuration front end
`timescale 1ns/1ps
module gmac_control_config_bench;
    typedef struct packed {logic [31:0] ctrl; logic [2:0] pins; logic [9:0] exp;} mode_row_t;
    typedef struct packed {logic [31:0] ctrl; logic [15:0] len; logic [4:0] kind; logic [9:0] exp;
        logic [9:0] mask;} frame_row_t;
    localparam logic [31:0] CTRL_RW = 32'h01c78cff;
    localparam logic [31:0] ID_VAL = {16'h5a3c, 5'h0a, 3'h5, 8'h7e}; // Arbitrary identity values
    localparam int DRAIN = 4;
    // Pins are {duplex, speed, short gap request}; outputs {fd, gig, gap, a, b, gmii_rst_b, loop, pace, txf, rxf}
    localparam mode_row_t MODE_ROWS [14] = '{
        {32'h00000000, 3'b001, 10'b0000000000}, {32'h00000001, 3'b000, 10'b1000000000},
        {32'h00000080, 3'b000, 10'b1100000000}, {32'h00020000, 3'b000, 10'b1100000000},
        {32'h00040000, 3'b100, 10'b1000000000}, {32'h00040081, 3'b000, 10'b0000000000},
        {32'h00040000, 3'b010, 10'b1100000000}, {32'h00000400, 3'b001, 10'b0010000000},
        {32'h00000400, 3'b000, 10'b0000000000}, {32'h00008000, 3'b000, 10'b0001000000},
        {32'h00010000, 3'b000, 10'b0000100000}, {32'h00000020, 3'b000, 10'b0000010000},
        {32'h00000002, 3'b000, 10'b1000001000}, {32'h00000059, 3'b000, 10'b1000000111}};
    // Kind is {crc, align, code, control, pause}
    localparam frame_row_t FRAME_ROWS [14] = '{
        {32'h00000000, 16'h0040, 5'b00000, 10'b1100000000, 10'b1111111111},
        {32'h00000000, 16'h0040, 5'b00010, 10'b1000000000, 10'b1100000011},
        {32'h00000010, 16'h0040, 5'b00010, 10'b1000000001, 10'b1100000011},
        {32'h01000010, 16'h0040, 5'b00010, 10'b1110000001, 10'b1111111111},
        {32'h00000011, 16'h0040, 5'b00011, 10'b1000000010, 10'b1100000010},
        {32'h00000010, 16'h0040, 5'b00011, 10'b1000000000, 10'b1100000010},
        {32'h01000011, 16'h0040, 5'b00011, 10'b1110000010, 10'b1111111110},
        {32'h00000000, 16'h003f, 5'b00000, 10'b1000000000, 10'b1100000011},
        {32'h00800000, 16'h003f, 5'b00000, 10'b1100100000, 10'b1111111111},
        {32'h00800000, 16'h003f, 5'b10000, 10'b1101000000, 10'b1111100011},
        {32'h00000000, 16'h0100, 5'b01000, 10'b1000000000, 10'b1100000011},
        {32'h00400000, 16'h0100, 5'b00100, 10'b1100000100, 10'b1111111111},
        {32'h00400000, 16'h0100, 5'b10000, 10'b1100010000, 10'b1111111111},
        {32'h00400000, 16'h0100, 5'b01000, 10'b1100001000, 10'b1111111111}};

    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] be = 4'hf;
    logic [31:0] rdata;
    logic wait_req;
    logic dpin = 1'b0;
    logic spin = 1'b0;
    logic greq = 1'b0;
    logic send = 1'b0;
    logic [3:0] blen = 4'h0;
    mac_cfg_pkg::rx_frame_t fin = '0;
    mac_cfg_pkg::rx_frame_t frame;
    mac_cfg_pkg::rx_verdict_t verdict;
    logic busy;
    logic fd, speed_1000_sel, gap, ia, ib, grst, lb, pace, txf, rxf, idle;
    logic [9:0] mode_seen;
    logic [31:0] q;
    int err_count = 0;
    int tests_run = 0;
    int n;

    assign mode_seen = {fd, speed_1000_sel, gap, ia, ib, grst, lb, pace, txf, rxf};
    always #25 clk = ~clk;

    phy_frame_model i_phy (.clk_in(clk), .rst_b_in(rst_b), .send_in(send), .frame_in(fin), .busy_len_in(blen),
        .frame_out(frame), .busy_out(busy));

    mac_control_config #(.IDENT(ID_VAL[31:16]), .VER_Z(ID_VAL[15:11]), .VER_X(ID_VAL[10:8]), .VER_Y(ID_VAL[7:0]),
        .IDLE_DRAIN(DRAIN)) i_dut (.ref_clk_in(clk), .rst_b_in(rst_b), .avs_address_in(addr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wait_req), .duplex_pin_in(dpin), .speed_pin_in(spin), .short_gap_req_in(greq),
        .tx_busy_in(busy), .rx_frame_in(frame), .rx_verdict_out(verdict), .full_duplex_out(fd), .gigabit_out(speed_1000_sel),
        .short_gap_out(gap), .iface_output_a_out(ia), .iface_output_b_out(ib), .gmii_rst_b_out(grst),
        .idle_out(idle), .loopback_out(lb), .tx_pace_out(pace), .tx_flow_en_out(txf), .rx_flow_en_out(rxf));

    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task give_verdict();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Holds the request until the edge that samples waitrequest low, then takes data and releases
    task bus_op(input logic is_wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
        int k;
        k = 0;
        @(posedge clk);
        addr <= a;
        wdata <= d;
        be <= b;
        rd <= !is_wr;
        wr <= is_wr;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (wait_req !== 1'b0 && k < 20);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        check("bus answer", {31'h0, k < 20}, 32'h00000001);
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
        bus_op(1'b0, a, 32'h00000000, 4'hf);
        check(nm, q, e);
    endtask

    task reset_run();
        rst_b <= 1'b0;
        repeat (8) @(posedge clk);
        check("waitrequest in reset", {31'h0, wait_req}, 32'h00000001);
        check("gmii reset in reset", {22'h0, mode_seen}, 32'h00000000);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
    endtask

    initial
    begin
        repeat (5000) @(posedge clk);
        err_count++;
        give_verdict();
    end

    initial
    begin
        reset_run();
        rd_chk(mac_cfg_pkg::CTRL_OFFSET, 32'h00000000, "control reset");
        rd_chk(mac_cfg_pkg::ID_OFFSET, ID_VAL, "identification");
        foreach (MODE_ROWS[i])
        begin
            {dpin, spin, greq} <= MODE_ROWS[i].pins;
            bus_op(1'b1, mac_cfg_pkg::CTRL_OFFSET, MODE_ROWS[i].ctrl, 4'hf);
            repeat (2) @(posedge clk);
            check("mode outputs", {22'h0, mode_seen},
                {22'h0, MODE_ROWS[i].exp});
            rd_chk(mac_cfg_pkg::CTRL_OFFSET, MODE_ROWS[i].ctrl, "control readback");
        end
        foreach (FRAME_ROWS[i])
        begin
            bus_op(1'b1, mac_cfg_pkg::CTRL_OFFSET, FRAME_ROWS[i].ctrl, 4'hf);
            @(posedge clk);
            fin <= {1'b0, FRAME_ROWS[i].len, FRAME_ROWS[i].kind};
            send <= 1'b1;
            @(posedge clk);
            send <= 1'b0;
            n = 0;
            do
            begin
                @(posedge clk);
                n++;
            end
            while (verdict.valid !== 1'b1 && n < 10);
            check("frame verdict", {22'h0, verdict & FRAME_ROWS[i].mask},
                {22'h0, FRAME_ROWS[i].exp & FRAME_ROWS[i].mask});
        end
        bus_op(1'b1, mac_cfg_pkg::CTRL_OFFSET, 32'hffffffff, 4'hf);
        rd_chk(mac_cfg_pkg::CTRL_OFFSET, CTRL_RW, "reserved bits");
        bus_op(1'b1, mac_cfg_pkg::CTRL_OFFSET, 32'h00000000, 4'h1);
        rd_chk(mac_cfg_pkg::CTRL_OFFSET, CTRL_RW & 32'hffffff00, "byte enable");
        bus_op(1'b1, mac_cfg_pkg::ID_OFFSET, 32'h00000000, 4'hf);
        rd_chk(mac_cfg_pkg::ID_OFFSET, ID_VAL, "identification write");
        bus_op(1'b1, 8'h10, 32'h00000000, 4'hf);
        rd_chk(8'h0c, 32'h00000000, "unmapped read");
        rd_chk(mac_cfg_pkg::CTRL_OFFSET, CTRL_RW & 32'hffffff00, "unmapped write");
        // Idle is commanded while the line is still busy, so the drain count must start late
        bus_op(1'b1, mac_cfg_pkg::CTRL_OFFSET, 32'h00000000, 4'hf);
        {dpin, spin, greq} <= 3'b100;
        @(posedge clk);
        fin <= {1'b0, 16'h0040, 5'b00000};
        blen <= 4'hc;
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
        bus_op(1'b1, mac_cfg_pkg::CTRL_OFFSET, 32'h00000800, 4'hf);
        check("idle while busy", {30'h0, busy, idle}, 32'h00000002);
        n = 0;
        while (busy === 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        n = 0;
        while (idle !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        check("idle drain", {31'h0, n >= DRAIN && n <= DRAIN + 2}, 32'h00000001);
        rd_chk(mac_cfg_pkg::STATUS_OFFSET, 32'h80000008, "status idle");
        bus_op(1'b1, mac_cfg_pkg::CTRL_OFFSET, 32'h00000020, 4'hf);
        repeat (2) @(posedge clk);
        check("idle released", {31'h0, idle}, 32'h00000000);
        rd_chk(mac_cfg_pkg::STATUS_OFFSET, 32'h00000008, "status run");
        @(posedge clk);
        reset_run();
        rd_chk(mac_cfg_pkg::CTRL_OFFSET, 32'h00000000, "control after reset");
        give_verdict();
    end
endmodule // gmac_control_config_bench
